// file: hw/ecit_top.sv
// Edge capture and interval timer block with an AXI4-Lite register slave.
`timescale 1ns/10ps
`include "ecit_defs.svh"
module ecit_top
  import ecit_pkg::*;
#(
  parameter int CAPT_DIV = `ECIT_CAPT_DIV, // Reference cycles per capture clock tick.
  parameter int PIT_DIV  = `ECIT_PIT_DIV   // Reference cycles per interval tick.
) (
  input  wire logic        ref_clk_in,       // 10 MHz clock.
  input  wire logic        resetn_in,        // Asynchronous reset, active low.
  input  wire logic        capture_in_a,     // Capture pin A.
  input  wire logic        capture_in_b,     // Capture pin B.
  input  wire logic [7:0]  s_axi_awaddr_in,  // Write address.
  input  wire logic        s_axi_awvalid_in, // Write address valid.
  output logic             s_axi_awready_out,// Write address ready.
  input  wire logic [31:0] s_axi_wdata_in,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb_in,   // Write strobes.
  input  wire logic        s_axi_wvalid_in,  // Write data valid.
  output logic             s_axi_wready_out, // Write data ready.
  output logic [1:0]       s_axi_bresp_out,  // Write response.
  output logic             s_axi_bvalid_out, // Write response valid.
  input  wire logic        s_axi_bready_in,  // Write response ready.
  input  wire logic [7:0]  s_axi_araddr_in,  // Read address.
  input  wire logic        s_axi_arvalid_in, // Read address valid.
  output logic             s_axi_arready_out,// Read address ready.
  output logic [31:0]      s_axi_rdata_out,  // Read data.
  output logic [1:0]       s_axi_rresp_out,  // Read response.
  output logic             s_axi_rvalid_out, // Read data valid.
  input  wire logic        s_axi_rready_in,  // Read data ready.
  output logic             irq_out           // Level interrupt, active high.
);
  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [15:0]   frc_q;
  logic [7:0]    frc_hold_q;
  logic [15:0]   capt_div_q;
  logic [15:0]   pit_div_q;
  logic          capt_tick_q;
  ecit_byte_type cap_q [4];
  logic [3:0]    hold_q;
  ecit_cfg_type  cfg_q;
  logic [3:0]    irq_en_q;
  logic [3:0]    status_q;
  logic          pit_en_q;
  logic          pit_pend_q;
  ecit_byte_type rld_lo_q;
  logic [3:0]    rld_hi_q;
  logic          a_rise;
  logic          a_fall;
  logic          b_rise;
  logic          b_fall;
  logic [7:0]    slice;
  logic [3:0]    ev;
  logic [3:0]    ld;
  logic [3:0]    rd_cap;
  logic          aw_full_q;
  logic          w_full_q;
  logic [5:0]    aw_idx_q;
  logic [7:0]    wdata_q;
  logic          wbyte_q;
  logic          wr_go;
  logic          ar_hs;
  logic [5:0]    ar_idx;
  logic [7:0]    rd_d;
  logic          rd_ok;
  logic          wr_ok;

  ecit_pit_if pit_bus ();

  // ****************************************************************
  // Pin edges and interval core.
  // ****************************************************************
  ecit_edge_det u_edge_a (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .pin_in    (capture_in_a),
    .rise_out  (a_rise),
    .fall_out  (a_fall)
  );

  ecit_edge_det u_edge_b (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .pin_in    (capture_in_b),
    .rise_out  (b_rise),
    .fall_out  (b_fall)
  );

  ecit_interval u_pit (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .pit       (pit_bus.pit)
  );

  // ****************************************************************
  // Clock dividers and free-running counter.
  // ****************************************************************

  // Both slow rates are enable pulses so the block stays on one clock.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      capt_div_q   <= `ECIT_RST_WORD;
      pit_div_q    <= `ECIT_RST_WORD;
      capt_tick_q  <= 1'b0;
      pit_bus.tick <= 1'b0;
    end else begin
      capt_tick_q  <= (capt_div_q == 16'(CAPT_DIV - 1));
      pit_bus.tick <= (pit_div_q == 16'(PIT_DIV - 1));
      capt_div_q   <= (capt_div_q == 16'(CAPT_DIV - 1)) ? 16'h0000 : capt_div_q + 16'h0001;
      pit_div_q    <= (pit_div_q == 16'(PIT_DIV - 1)) ? 16'h0000 : pit_div_q + 16'h0001;
    end
  end

  // Low read latches the high byte so software sees one coherent value.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frc_q      <= `ECIT_RST_WORD;
      frc_hold_q <= `ECIT_RST_BYTE;
    end else begin
      if (capt_tick_q) begin
        frc_q <= frc_q + 16'h0001;
      end
      if (ar_hs && ar_idx == `ECIT_IDX_FRC_LO) begin
        frc_hold_q <= frc_q[15:8];
      end
    end
  end

  // ****************************************************************
  // Capture loading.
  // ****************************************************************

  // The prescale code shifts the counter so bits n+7..n land in the byte.
  assign slice = 8'(frc_q >> cfg_q.prescale);
  assign ev    = {b_fall, b_rise, a_fall, a_rise};

  // Register order is A rise, A fall, B rise, B fall. In combined mode the
  // B registers follow A's loads, so a held A also freezes its upper byte.
  always_comb begin
    ld[0] = ev[0] & ~(cfg_q.first_hold & hold_q[0]);
    ld[1] = ev[1] & ~(cfg_q.first_hold & hold_q[1]);
    if (cfg_q.combine_wide_capture) begin
      ld[2] = ld[0];
      ld[3] = ld[1];
    end else begin
      ld[2] = b_rise & ~(cfg_q.first_hold & hold_q[2]);
      ld[3] = b_fall & ~(cfg_q.first_hold & hold_q[3]);
    end
  end

  // Read strobes for the four capture registers, same order.
  assign rd_cap = {ar_hs && ar_idx == `ECIT_IDX_B_FALL,
                   ar_hs && ar_idx == `ECIT_IDX_B_RISE,
                   ar_hs && ar_idx == `ECIT_IDX_A_FALL,
                   ar_hs && ar_idx == `ECIT_IDX_A_RISE};

  // Hardware loads win over a software write in the same cycle.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 4; i++) begin
        cap_q[i] <= `ECIT_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ld[i]) begin
          if (cfg_q.combine_wide_capture) begin
            cap_q[i] <= (i < 2) ? frc_q[7:0] : frc_q[15:8];
          end else begin
            cap_q[i] <= slice;
          end
        end else if (wr_go && wbyte_q && aw_idx_q == wr_cap_idx(i)) begin
          cap_q[i] <= wdata_q;
        end
      end
    end
  end

  // A hold flag marks a register that keeps its first edge until read.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_q <= `ECIT_RST_NIB;
    end else if (!cfg_q.first_hold) begin
      hold_q <= `ECIT_RST_NIB;
    end else begin
      hold_q <= (hold_q & ~rd_cap) | ld;
    end
  end

  // Maps a capture slot to its register index.
  function automatic logic [5:0] wr_cap_idx(input int slot);
    logic [5:0] r;
    r = `ECIT_IDX_A_RISE;
    unique case (slot)
      0: r = `ECIT_IDX_A_RISE;
      1: r = `ECIT_IDX_A_FALL;
      2: r = `ECIT_IDX_B_RISE;
      default: r = `ECIT_IDX_B_FALL;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Status, enables and interrupt.
  // ****************************************************************

  // A new edge wins over a write-one clear arriving in the same cycle.
  // B's edges are ignored while the captures are combined.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_q   <= `ECIT_RST_NIB;
      pit_pend_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~((wr_go && wbyte_q && aw_idx_q == `ECIT_IDX_IRQ_STAT) ?
                   wdata_q[3:0] : 4'h0))
                  | {ev[3:2] & {2{~cfg_q.combine_wide_capture}}, ev[1:0]};
      pit_pend_q <= (pit_pend_q & ~(wr_go && wbyte_q && aw_idx_q == `ECIT_IDX_PIT_IRQ &&
                     wdata_q[`ECIT_PIT_PEND_BIT])) | pit_bus.expire;
    end
  end

  // Software-written control bytes; these steer capture and interrupts.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_q    <= ecit_cfg_type'(`ECIT_RST_BYTE);
      irq_en_q <= `ECIT_RST_NIB;
      pit_en_q <= 1'b0;
      rld_lo_q <= `ECIT_RST_BYTE;
      rld_hi_q <= `ECIT_RST_NIB;
    end else if (wr_go && wbyte_q) begin
      unique case (aw_idx_q)
        `ECIT_IDX_CONFIG:  cfg_q    <= ecit_cfg_type'({wdata_q[7:3], 3'h0});
        `ECIT_IDX_IRQ_EN:  irq_en_q <= wdata_q[3:0];
        `ECIT_IDX_PIT_IRQ: pit_en_q <= wdata_q[`ECIT_PIT_EN_BIT];
        `ECIT_IDX_RLD_LO:  rld_lo_q <= wdata_q;
        `ECIT_IDX_RLD_HI:  rld_hi_q <= wdata_q[3:0];
        default: ;
      endcase
    end
  end

  // The reload pair is used as stored; the timer picks it up at its next
  // terminal count, so one that falls between the low and high writes loads a mix of two values.
  assign pit_bus.reload = {rld_hi_q, rld_lo_q};
  assign pit_bus.rd_low = ar_hs && ar_idx == `ECIT_IDX_PIT_LO;

  // Registered level interrupt from any enabled pending source.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_q & irq_en_q) | (pit_pend_q & pit_en_q);
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid_out;

  // Address and data are taken in either order; the write lands once both are held.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_full_q         <= 1'b0;
      w_full_q          <= 1'b0;
      aw_idx_q          <= 6'h00;
      wdata_q           <= `ECIT_RST_BYTE;
      wbyte_q           <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `ECIT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_q         <= 1'b1;
        aw_idx_q          <= s_axi_awaddr_in[7:2];
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_q         <= 1'b1;
        wdata_q          <= s_axi_wdata_in[7:0];
        wbyte_q          <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q        <= 1'b0;
        w_full_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Read-only and unmapped words answer with an error on writes.
  assign wr_ok = (aw_idx_q >= `ECIT_IDX_A_RISE) && (aw_idx_q <= `ECIT_IDX_PIT_IRQ) &&
                 (aw_idx_q != `ECIT_IDX_PIT_LO) && (aw_idx_q != `ECIT_IDX_PIT_HI);

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  assign ar_hs  = s_axi_arvalid_in & s_axi_arready_out;
  assign ar_idx = s_axi_araddr_in[7:2];

  // Read data multiplexer; reserved bits read as zero.
  always_comb begin
    rd_d  = 8'h00;
    rd_ok = 1'b1;
    unique case (ar_idx)
      `ECIT_IDX_FRC_LO:   rd_d = frc_q[7:0];
      `ECIT_IDX_FRC_HI:   rd_d = frc_hold_q;
      `ECIT_IDX_A_RISE:   rd_d = cap_q[0];
      `ECIT_IDX_A_FALL:   rd_d = cap_q[1];
      `ECIT_IDX_B_RISE:   rd_d = cap_q[2];
      `ECIT_IDX_B_FALL:   rd_d = cap_q[3];
      `ECIT_IDX_PIT_LO:   rd_d = pit_bus.count[7:0];
      `ECIT_IDX_PIT_HI:   rd_d = {4'h0, pit_bus.nib_hold};
      `ECIT_IDX_RLD_LO:   rd_d = rld_lo_q;
      `ECIT_IDX_RLD_HI:   rd_d = {4'h0, rld_hi_q};
      `ECIT_IDX_CONFIG:   rd_d = cfg_q;
      `ECIT_IDX_IRQ_EN:   rd_d = {4'h0, irq_en_q};
      `ECIT_IDX_IRQ_STAT: rd_d = {4'h0, status_q};
      `ECIT_IDX_PIT_IRQ:  rd_d = {6'h00, pit_pend_q, pit_en_q};
      default:            rd_ok = 1'b0;
    endcase
  end

  // One read at a time: data is registered the cycle after the address.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `ECIT_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= {24'h000000, rd_d};
      s_axi_rresp_out   <= rd_ok ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence a_rise_free;
    a_rise && !(cfg_q.first_hold && hold_q[0]);
  endsequence

  sequence stat_clear(int b);
    wr_go && wbyte_q && aw_idx_q == `ECIT_IDX_IRQ_STAT && wdata_q[b] && !ev[b];
  endsequence

  frc_step_a: assert property (capt_tick_q |=> frc_q == $past(frc_q) + 16'h0001)
    else $error("Counter did not step.");
  a_rise_slice_a: assert property (a_rise_free and !cfg_q.combine_wide_capture |=>
    cap_q[0] == 8'($past(frc_q) >> $past(cfg_q.prescale))) else $error("A rise slice wrong.");
  b_fall_slice_a: assert property (ld[3] && !cfg_q.combine_wide_capture |=>
    cap_q[3] == $past(slice)) else $error("B fall slice wrong.");
  wide_upper_a: assert property (a_fall && ld[1] && cfg_q.combine_wide_capture |=>
    cap_q[3] == $past(frc_q[15:8]) && cap_q[1] == $past(frc_q[7:0]))
    else $error("Combined fall capture wrong.");
  wide_lower_a: assert property (a_rise_free and cfg_q.combine_wide_capture |=>
    cap_q[0] == $past(frc_q[7:0])) else $error("Combined rise low byte wrong.");
  first_hold_a: assert property (cfg_q.first_hold && hold_q[0] && !rd_cap[0] &&
    !(wr_go && wbyte_q && aw_idx_q == `ECIT_IDX_A_RISE) ##1
    cfg_q.first_hold |-> $stable(cap_q[0])) else $error("Held capture changed.");
  stat_set_a: assert property (a_rise or b_fall && !cfg_q.combine_wide_capture |=>
    (status_q[0] || !$past(a_rise)) &&
    (status_q[3] || !$past(b_fall && !cfg_q.combine_wide_capture)))
    else $error("Status not set.");
  stat_w1c_a: assert property (stat_clear(1) |=> !status_q[1])
    else $error("Status bit not cleared.");
  irq_level_a: assert property ((status_q & irq_en_q) != 4'h0 |=> irq_out)
    else $error("Interrupt not raised.");
  irq_quiet_a: assert property ((status_q & irq_en_q) == 4'h0 && !(pit_pend_q && pit_en_q)
    |=> !irq_out) else $error("Interrupt without source.");
  pit_high_a: assert property (ar_hs && ar_idx == `ECIT_IDX_PIT_HI |=>
    s_axi_rdata_out[7:4] == 4'h0 && s_axi_rdata_out[3:0] == $past(pit_bus.nib_hold))
    else $error("Interval high read wrong.");
endmodule

// file: hw/ecit_defs.svh
// Register offsets, field positions and reset values of the edge capture and interval timer.
`ifndef ECIT_DEFS_SVH
`define ECIT_DEFS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define ECIT_IDX_FRC_LO     6'h20
`define ECIT_IDX_FRC_HI     6'h21
`define ECIT_IDX_A_RISE     6'h22
`define ECIT_IDX_B_RISE     6'h23
`define ECIT_IDX_A_FALL     6'h24
`define ECIT_IDX_B_FALL     6'h25
`define ECIT_IDX_PIT_LO     6'h26
`define ECIT_IDX_PIT_HI     6'h27
`define ECIT_IDX_RLD_LO     6'h28
`define ECIT_IDX_RLD_HI     6'h29
`define ECIT_IDX_CONFIG     6'h2A
`define ECIT_IDX_IRQ_EN     6'h2B
`define ECIT_IDX_IRQ_STAT   6'h2C
`define ECIT_IDX_PIT_IRQ    6'h2D

// ****************************************************************
// Field positions, reset values and bus answers.
// ****************************************************************
`define ECIT_CFG_HOLD_BIT   7
`define ECIT_CFG_PRE_MSB    6
`define ECIT_CFG_PRE_LSB    4
`define ECIT_CFG_COMB_BIT   3
`define ECIT_PIT_EN_BIT     0
`define ECIT_PIT_PEND_BIT   1
`define ECIT_RST_BYTE       8'h00
`define ECIT_RST_NIB        4'h0
`define ECIT_RST_WORD       16'h0000
`define ECIT_RST_PIT        12'h000
`define ECIT_RESP_OKAY      2'h0
`define ECIT_RESP_SLVERR    2'h2
`define ECIT_CAPT_DIV       4
`define ECIT_PIT_DIV        10

`endif

// file: hw/ecit_pkg.sv
// Shared types of the edge capture and interval timer.
package ecit_pkg;

  // One register byte.
  typedef logic [7:0] ecit_byte_type;

  // Layout of the capture configuration register.
  typedef struct packed {
    logic       first_hold;
    logic [2:0] prescale;
    logic       combine_wide_capture;
    logic [2:0] reserved;
  } ecit_cfg_type;

endpackage

// file: hw/ecit_pit_if.sv
// Signals between the register block and the interval timer core.
`timescale 1ns/10ps
interface ecit_pit_if;
  logic        tick;      // One-cycle count enable.
  logic [11:0] reload;    // Reload value.
  logic        rd_low;    // Low count byte is being read.
  logic [11:0] count;     // Live count.
  logic [3:0]  nib_hold;  // Upper nibble held at the last low read.
  logic        expire;    // Terminal count pulse.

  modport regs (output tick, reload, rd_low, input count, nib_hold, expire);
  modport pit  (input tick, reload, rd_low, output count, nib_hold, expire);
endinterface

// file: hw/ecit_edge_det.sv
// Pin synchroniser with rising and falling edge pulses.
`timescale 1ns/10ps
module ecit_edge_det (
  input  wire logic clk_in,     // System clock.
  input  wire logic resetn_in,  // Asynchronous reset, active low.
  input  wire logic pin_in,     // Asynchronous capture pin.
  output logic      rise_out,   // One-cycle rising edge pulse.
  output logic      fall_out    // One-cycle falling edge pulse.
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // Two flops tame metastability; only the second one is compared.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      prev_q   <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      sync1_q  <= pin_in;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      rise_out <= sync2_q & ~prev_q;
      fall_out <= ~sync2_q & prev_q;
    end
  end
endmodule

// file: hw/ecit_interval.sv
// Twelve-bit down-counting interval timer with auto reload and nibble hold.
`timescale 1ns/10ps
`include "ecit_defs.svh"
module ecit_interval (
  input  wire logic clk_in,     // System clock.
  input  wire logic resetn_in,  // Asynchronous reset, active low.
  ecit_pit_if.pit   pit         // Link to the register block.
);
  // Count down on each tick; at zero signal expiry and reload.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pit.count  <= `ECIT_RST_PIT;
      pit.expire <= 1'b0;
    end else begin
      pit.expire <= 1'b0;
      if (pit.tick) begin
        if (pit.count == 12'h000) begin
          pit.count  <= pit.reload;
          pit.expire <= 1'b1;
        end else begin
          pit.count <= pit.count - 12'h001;
        end
      end
    end
  end

  // Reading the low byte freezes the upper nibble for a coherent pair.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pit.nib_hold <= `ECIT_RST_NIB;
    end else if (pit.rd_low) begin
      pit.nib_hold <= pit.count[11:8];
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  pit_reload_a: assert property (pit.tick && pit.count == 12'h000 |=>
    pit.expire && pit.count == $past(pit.reload)) else $error("Interval reload wrong.");
  pit_hold_a: assert property (pit.rd_low |=> pit.nib_hold == $past(pit.count[11:8]))
    else $error("Interval nibble not held.");
endmodule

// file: sim/ecit_pin_drv.sv
// Far-side model that drives the two capture pins.
`timescale 1ns/10ps
module ecit_pin_drv (
  input  wire logic clk_in,     // Reference clock.
  output logic      pin_a_out,  // Capture pin A.
  output logic      pin_b_out   // Capture pin B.
);
  // Both pins idle low until a pulse is asked for.
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // One high pulse; each level stays at least two cycles so the synchroniser sees it.
  task automatic pulse(input logic sel_b, input int high_cyc, input int low_cyc);
    @(posedge clk_in);
    if (sel_b) pin_b_out <= 1'b1; else pin_a_out <= 1'b1;
    repeat (high_cyc) @(posedge clk_in);
    if (sel_b) pin_b_out <= 1'b0; else pin_a_out <= 1'b0;
    repeat (low_cyc) @(posedge clk_in);
  endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the edge capture and interval timer.
`timescale 1ns/10ps
`include "ecit_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0;
  logic        r_rdy = 1'b0, aw_r, w_r, b_v, ar_r, r_v, irq, pin_a, pin_b;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00, v0, v1, v2, v3;
  logic [31:0] w_d = 32'h0, r_d;
  logic [1:0]  b_rs, r_rs;
  int          n_errors = 0, cmp_count = 0;
  // Small dividers keep the long spans short; every span below is scaled by two.
  ecit_top #(.CAPT_DIV(2), .PIT_DIV(2)) dut_u (.ref_clk_in(clk), .resetn_in(rst_n),
    .capture_in_a(pin_a), .capture_in_b(pin_b), .s_axi_awaddr_in(aw_a),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r),
    .s_axi_bresp_out(b_rs), .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_rdy),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r),
    .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs), .s_axi_rvalid_out(r_v),
    .s_axi_rready_in(r_rdy), .irq_out(irq));
  ecit_pin_drv pins_u (.clk_in(clk), .pin_a_out(pin_a), .pin_b_out(pin_b));
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write cycle; each valid drops at the edge where its own ready is seen.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    aw_a <= {idx, 2'b00};
    w_d <= {24'h000000, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    fork
      begin do @(posedge clk); while (!aw_r); aw_v <= 1'b0; end
      begin do @(posedge clk); while (!w_r); w_v <= 1'b0; end
    join
    do @(posedge clk); while (!b_v);
    // Ready stays high between calls so back-to-back writes never drive it twice in one step.
    `CHK("bresp", er, b_rs)
  endtask
  // Read cycle; data is taken at the edge where rvalid is seen.
  task automatic rd(input logic [5:0] idx, input logic [1:0] er, output logic [7:0] d);
    ar_a <= {idx, 2'b00};
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do @(posedge clk); while (!ar_r);
    ar_v <= 1'b0;
    do @(posedge clk); while (!r_v);
    d = r_d[7:0];
    `CHK("rresp", er, r_rs)
  endtask
  task automatic rc(input logic [5:0] idx, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(idx, `ECIT_RESP_OKAY, d);
    `CHK(nm, e, d)
  endtask
  // Watchdog: the whole sequence needs well under 5000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
  // Main sequence; capture checks compare spans, so the counter phase does not matter.
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(`ECIT_IDX_CONFIG, 8'h00, "config");
    rc(`ECIT_IDX_IRQ_STAT, 8'h00, "status");
    rc(`ECIT_IDX_B_FALL, 8'h00, "b_fall");
    rd(6'h3F, `ECIT_RESP_SLVERR, v0);
    wr(`ECIT_IDX_PIT_LO, 8'h55, `ECIT_RESP_SLVERR);
    wr(`ECIT_IDX_RLD_LO, 8'hFF, `ECIT_RESP_OKAY);
    wr(`ECIT_IDX_RLD_HI, 8'hFF, `ECIT_RESP_OKAY);
    rc(`ECIT_IDX_RLD_HI, 8'h0F, "reload_high");
    // Drop the pending flag set by the zero-count expiries after reset so only the next expiry can set it.
    wr(`ECIT_IDX_PIT_IRQ, 8'h02, `ECIT_RESP_OKAY);
    // The low reload may be taken alone first; let that shorter run expire.
    repeat (600) @(posedge clk);
    rc(`ECIT_IDX_PIT_IRQ, 8'h02, "pit_pending");
    rd(`ECIT_IDX_PIT_LO, `ECIT_RESP_OKAY, v0);
    rc(`ECIT_IDX_PIT_HI, 8'h0F, "count_high");
    wr(`ECIT_IDX_CONFIG, 8'h80, `ECIT_RESP_OKAY);
    pins_u.pulse(1'b0, 20, 20);
    pins_u.pulse(1'b0, 60, 8);
    rd(`ECIT_IDX_A_RISE, `ECIT_RESP_OKAY, v0);
    rd(`ECIT_IDX_A_FALL, `ECIT_RESP_OKAY, v1);
    `CHK("hold_span", 8'h0A, 8'(v1 - v0))
    wr(`ECIT_IDX_CONFIG, 8'h00, `ECIT_RESP_OKAY);
    wr(`ECIT_IDX_IRQ_STAT, 8'h0F, `ECIT_RESP_OKAY);
    pins_u.pulse(1'b1, 20, 20);
    pins_u.pulse(1'b1, 60, 8);
    rd(`ECIT_IDX_B_RISE, `ECIT_RESP_OKAY, v0);
    rd(`ECIT_IDX_B_FALL, `ECIT_RESP_OKAY, v1);
    `CHK("recent_span", 8'h1E, 8'(v1 - v0))
    pins_u.pulse(1'b0, 4, 8);
    rc(`ECIT_IDX_IRQ_STAT, 8'h0F, "status_all");
    `CHK("irq_masked", 1'b0, irq)
    wr(`ECIT_IDX_IRQ_EN, 8'h01, `ECIT_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq_on", 1'b1, irq)
    wr(`ECIT_IDX_IRQ_STAT, 8'h01, `ECIT_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq_cleared", 1'b0, irq)
    rc(`ECIT_IDX_IRQ_STAT, 8'h0E, "status_w1c");
    // Every prescale code: a span of three slice steps reads back as three.
    for (int n = 0; n < 8; n++) begin
      wr(`ECIT_IDX_CONFIG, {1'b0, 3'(n), 4'h0}, `ECIT_RESP_OKAY);
      pins_u.pulse(1'b0, 6 << n, 8);
      rd(`ECIT_IDX_A_RISE, `ECIT_RESP_OKAY, v0);
      rd(`ECIT_IDX_A_FALL, `ECIT_RESP_OKAY, v1);
      `CHK("prescale_span", 8'h03, 8'(v1 - v0))
    end
    // Combined mode: a 300-count span crosses the byte boundary; pin B is ignored.
    wr(`ECIT_IDX_CONFIG, 8'h08, `ECIT_RESP_OKAY);
    wr(`ECIT_IDX_IRQ_STAT, 8'h0F, `ECIT_RESP_OKAY);
    pins_u.pulse(1'b0, 600, 8);
    pins_u.pulse(1'b1, 40, 8);
    rd(`ECIT_IDX_A_RISE, `ECIT_RESP_OKAY, v0);
    rd(`ECIT_IDX_B_RISE, `ECIT_RESP_OKAY, v1);
    rd(`ECIT_IDX_A_FALL, `ECIT_RESP_OKAY, v2);
    rd(`ECIT_IDX_B_FALL, `ECIT_RESP_OKAY, v3);
    `CHK("wide_span", 16'h012C, 16'({v3, v2} - {v1, v0}))
    rc(`ECIT_IDX_IRQ_STAT, 8'h03, "wide_status");
    results();
  end
endmodule
